// ==== pkg/vre_map.svh ====
/*
 * Register map, reset values and bus codes of the raw request and enable stage.
 * Assumes a 32-bit AXI4-Lite byte address; every register is one aligned word.
 */
`ifndef VRE_MAP_SVH
`define VRE_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define VRE_ADDR_RAW_STATUS 32'hFFFF_F008
`define VRE_ADDR_ENABLE_SET 32'hFFFF_F010
`define VRE_ADDR_FORCED 32'hFFFF_F018
`define VRE_ADDR_FORCED_CLEAR 32'hFFFF_F01C
`define VRE_ADDR_EVENT_STATUS 32'hFFFF_F040
`define VRE_ADDR_EVENT_MASK 32'hFFFF_F044

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define VRE_RESET_WORD 32'h0000_0000
`define VRE_DATA_WIDTH 32
`define VRE_LANE_COUNT 4
`define VRE_LANE_WIDTH 8

// ****************************************************************
// Response codes
// ****************************************************************
`define VRE_RESP_OKAY 2'h0
`define VRE_RESP_SLVERR 2'h2

`endif

// ==== pkg/vre_pkg.sv ====
/*
 * Types of the raw request and enable stage: the request vector layout and bus states.
 * Assumes the map header for widths; nothing here holds logic.
 */
package vre_pkg;

    // ****************************************************************
    // Request line layout, one bit per source
    // ****************************************************************
    typedef struct packed {  // [RL12] [RL13]
        logic [3:0] spare_31_28;
        logic counter_block_d_request;
        logic counter_block_c_request;
        logic [5:0] spare_25_20;
        logic two_wire_b_request;
        logic analog_converter_request;
        logic spare_17;
        logic external_pin_c_request;
        logic external_pin_b_request;
        logic external_pin_a_request;
        logic calendar_clock_request;
        logic freq_synth_request;
        logic sync_serial_b_request;
        logic sync_serial_a_request;
        logic two_wire_a_request;
        logic spare_8;
        logic async_serial_b_request;
        logic async_serial_a_request;
        logic counter_block_b_request;
        logic counter_block_a_request;
        logic processor_core_request_b;
        logic processor_core_request_a;
        logic spare_1;
        logic watchdog_request;
    } vre_req_vec_type;

    typedef enum logic [4:0] {
        WR_IDLE = 5'b0_0001,
        WR_HAVE_ADDR = 5'b0_0010,
        WR_HAVE_DATA = 5'b0_0100,
        WR_EXEC = 5'b0_1000,
        WR_RESP = 5'b1_0000
    } vre_wr_state_type;

endpackage : vre_pkg

// ==== design/vre_req_gate.sv ====
/*
 * Per-line request path: two-stage synchroniser, OR with the forced bits, enable gate.
 * Assumes request lines may come from any domain; forced and enable bits are local.
 */
`timescale 1ns/1ps
`include "vre_map.svh"

module vre_req_gate (
    input wire logic clk,
    input wire logic resetn,
    input wire vre_pkg::vre_req_vec_type req_in,
    input wire logic [`VRE_DATA_WIDTH-1:0] forced,
    input wire logic [`VRE_DATA_WIDTH-1:0] enable,
    output logic [`VRE_DATA_WIDTH-1:0] raw_status,
    output logic [`VRE_DATA_WIDTH-1:0] enabled_req
);

    logic [`VRE_DATA_WIDTH-1:0] req_meta;
    logic [`VRE_DATA_WIDTH-1:0] req_sync;
    logic [`VRE_DATA_WIDTH-1:0] req_flat;

    assign req_flat = req_in;  // [RL12] [RL13]

    // ****************************************************************
    // One slice per request line
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < `VRE_DATA_WIDTH; i = i + 1) begin : g_line
            // Meta stage feeds only the second stage
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    req_meta[i] <= 1'b0;
                    req_sync[i] <= 1'b0;
                end else begin
                    req_meta[i] <= req_flat[i];
                    req_sync[i] <= req_meta[i];
                end
            end

            assign raw_status[i] = req_sync[i] | forced[i];  // [RL1] [RL6] [RL7]

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    enabled_req[i] <= 1'b0;
                end else begin
                    enabled_req[i] <= raw_status[i] & enable[i];  // [RL8]
                end
            end
        end
    endgenerate

endmodule : vre_req_gate

// ==== design/vre_controller.sv ====
/*
 * Raw request and enable stage of a vectored interrupt controller, AXI4-Lite slave.
 * Assumes one clock, synchronous active-low reset, and a classifier fed by ENABLED_REQ.
 */
`timescale 1ns/1ps
`include "vre_map.svh"

// Notes on behaviour
// (RL1) Forced bits ORed into request lines first
// (RL2) Clear write one drops forced bit
// (RL3) Clear write zero keeps forced bit
// (RL4) Clear register 32 bits, write-only
// (RL5) Raw status read-only, shows combined lines
// (RL6) Raw bit zero when both sources negated
// (RL7) Raw bit one when either source asserted
// (RL8) Only enabled requests pass onward
// (RL9) Enable read shows enabled positions
// (RL10) Enable write ones set, zeros keep
// (RL11) Enable and raw view reset zero
// (RL12) Low-byte source positions fixed
// (RL13) Upper source positions fixed
module vre_controller (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [`VRE_DATA_WIDTH-1:0] S_AXI_WDATA,
    input wire logic [`VRE_LANE_COUNT-1:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [`VRE_DATA_WIDTH-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire vre_pkg::vre_req_vec_type IRQ_REQ_IN,
    output logic [`VRE_DATA_WIDTH-1:0] ENABLED_REQ,
    output logic IRQ_OUT
);

    vre_pkg::vre_wr_state_type wr_state;
    vre_pkg::vre_wr_state_type next_wr_state;
    logic [31:0] wr_addr;
    logic [`VRE_DATA_WIDTH-1:0] wr_data;
    logic [`VRE_LANE_COUNT-1:0] wr_strb;
    logic [`VRE_DATA_WIDTH-1:0] wr_mask;
    logic [`VRE_DATA_WIDTH-1:0] wr_ones;
    logic aw_take;
    logic w_take;
    logic wr_exec;
    logic [`VRE_DATA_WIDTH-1:0] forced;
    logic [`VRE_DATA_WIDTH-1:0] enable;
    logic [`VRE_DATA_WIDTH-1:0] event_status;
    logic [`VRE_DATA_WIDTH-1:0] event_mask;
    logic [`VRE_DATA_WIDTH-1:0] raw_status;
    logic ar_take;
    logic [`VRE_DATA_WIDTH-1:0] next_rdata;
    logic [1:0] next_rresp;

    // ****************************************************************
    // Request path
    // ****************************************************************
    vre_req_gate u_gate (
        .clk(MCLK),
        .resetn(RESETN),
        .req_in(IRQ_REQ_IN),
        .forced(forced),
        .enable(enable),
        .raw_status(raw_status),
        .enabled_req(ENABLED_REQ)
    );

    // ****************************************************************
    // Write channel
    // ****************************************************************
    assign S_AXI_AWREADY = (wr_state == vre_pkg::WR_IDLE) || (wr_state == vre_pkg::WR_HAVE_DATA);
    assign S_AXI_WREADY = (wr_state == vre_pkg::WR_IDLE) || (wr_state == vre_pkg::WR_HAVE_ADDR);
    assign S_AXI_BVALID = (wr_state == vre_pkg::WR_RESP);
    assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_take = S_AXI_WVALID && S_AXI_WREADY;
    assign wr_exec = (wr_state == vre_pkg::WR_EXEC);

    always_comb begin
        next_wr_state = wr_state;
        case (wr_state)
            vre_pkg::WR_IDLE: begin
                if (aw_take && w_take) begin
                    next_wr_state = vre_pkg::WR_EXEC;
                end else if (aw_take) begin
                    next_wr_state = vre_pkg::WR_HAVE_ADDR;
                end else if (w_take) begin
                    next_wr_state = vre_pkg::WR_HAVE_DATA;
                end
            end
            vre_pkg::WR_HAVE_ADDR: begin
                if (w_take) begin
                    next_wr_state = vre_pkg::WR_EXEC;
                end
            end
            vre_pkg::WR_HAVE_DATA: begin
                if (aw_take) begin
                    next_wr_state = vre_pkg::WR_EXEC;
                end
            end
            vre_pkg::WR_EXEC: begin
                next_wr_state = vre_pkg::WR_RESP;
            end
            vre_pkg::WR_RESP: begin
                if (S_AXI_BREADY) begin
                    next_wr_state = vre_pkg::WR_IDLE;
                end
            end
            default: begin
                next_wr_state = vre_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            wr_state <= vre_pkg::WR_IDLE;
        end else begin
            wr_state <= next_wr_state;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            wr_addr <= `VRE_RESET_WORD;
            wr_data <= `VRE_RESET_WORD;
            wr_strb <= '0;
        end else begin
            if (aw_take) begin
                wr_addr <= S_AXI_AWADDR;
            end
            if (w_take) begin
                wr_data <= S_AXI_WDATA;
                wr_strb <= S_AXI_WSTRB;
            end
        end
    end

    // Lanes with a low strobe write nothing, not zeros
    genvar lane;
    generate
        for (lane = 0; lane < `VRE_LANE_COUNT; lane = lane + 1) begin : g_lane
            assign wr_mask[lane*`VRE_LANE_WIDTH +: `VRE_LANE_WIDTH] = {`VRE_LANE_WIDTH{wr_strb[lane]}};
        end
    endgenerate
    assign wr_ones = wr_data & wr_mask;

    // Raw status takes no writes; it answers with an error
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            S_AXI_BRESP <= `VRE_RESP_OKAY;
        end else if (wr_exec) begin
            case (wr_addr)
                `VRE_ADDR_ENABLE_SET, `VRE_ADDR_FORCED, `VRE_ADDR_FORCED_CLEAR,
                `VRE_ADDR_EVENT_STATUS, `VRE_ADDR_EVENT_MASK: begin
                    S_AXI_BRESP <= `VRE_RESP_OKAY;
                end
                default: begin
                    S_AXI_BRESP <= `VRE_RESP_SLVERR;  // [RL5]
                end
            endcase
        end
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            forced <= `VRE_RESET_WORD;
        end else if (wr_exec && (wr_addr == `VRE_ADDR_FORCED)) begin
            forced <= forced | wr_ones;
        end else if (wr_exec && (wr_addr == `VRE_ADDR_FORCED_CLEAR)) begin
            forced <= forced & ~wr_ones;  // [RL2] [RL3]
        end
    end

    // No clear path here: disabling lives in a later stage
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            enable <= `VRE_RESET_WORD;  // [RL11]
        end else if (wr_exec && (wr_addr == `VRE_ADDR_ENABLE_SET)) begin
            enable <= enable | wr_ones;  // [RL10]
        end
    end

    // New events win over a same-cycle write-one clear
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            event_status <= `VRE_RESET_WORD;
        end else if (wr_exec && (wr_addr == `VRE_ADDR_EVENT_STATUS)) begin
            event_status <= (event_status & ~wr_ones) | ENABLED_REQ;
        end else begin
            event_status <= event_status | ENABLED_REQ;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            event_mask <= `VRE_RESET_WORD;
        end else if (wr_exec && (wr_addr == `VRE_ADDR_EVENT_MASK)) begin
            event_mask <= (event_mask & ~wr_mask) | wr_ones;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(event_status & event_mask);
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

    always_comb begin
        next_rdata = `VRE_RESET_WORD;
        next_rresp = `VRE_RESP_OKAY;
        case (S_AXI_ARADDR)
            `VRE_ADDR_RAW_STATUS: begin
                next_rdata = raw_status;  // [RL5]
            end
            `VRE_ADDR_ENABLE_SET: begin
                next_rdata = enable;  // [RL9]
            end
            `VRE_ADDR_FORCED: begin
                next_rdata = forced;
            end
            `VRE_ADDR_FORCED_CLEAR: begin
                next_rdata = `VRE_RESET_WORD;  // [RL4]
            end
            `VRE_ADDR_EVENT_STATUS: begin
                next_rdata = event_status;
            end
            `VRE_ADDR_EVENT_MASK: begin
                next_rdata = event_mask;
            end
            default: begin
                next_rresp = `VRE_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= `VRE_RESET_WORD;
            S_AXI_RRESP <= `VRE_RESP_OKAY;
        end else if (ar_take) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= next_rdata;
            S_AXI_RRESP <= next_rresp;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_exec_at(logic [31:0] a);
        wr_exec && (wr_addr == a);
    endsequence

    sequence s_read_at(logic [31:0] a);
        ar_take && (S_AXI_ARADDR == a);
    endsequence

    a_raw_combine: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL1] [RL7]
        s_exec_at(`VRE_ADDR_FORCED) |=> ((raw_status & $past(wr_ones)) == $past(wr_ones)))
        else $error("forced bit not seen in raw status");

    a_clear_ones: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL2]
        s_exec_at(`VRE_ADDR_FORCED_CLEAR) |=> ((forced & $past(wr_ones)) == `VRE_RESET_WORD))
        else $error("forced bit survived a clear");

    a_clear_zeros: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL3]
        s_exec_at(`VRE_ADDR_FORCED_CLEAR) |=> ((forced & ~$past(wr_ones)) == ($past(forced) & ~$past(wr_ones))))
        else $error("unwritten forced bit changed");

    a_clear_readback: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL4]
        s_read_at(`VRE_ADDR_FORCED_CLEAR) |=> S_AXI_RVALID && (S_AXI_RDATA == `VRE_RESET_WORD))
        else $error("clear register read not zero");

    a_raw_readback: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL5]
        s_read_at(`VRE_ADDR_RAW_STATUS) |=> (S_AXI_RDATA == $past(raw_status)) && (S_AXI_RRESP == `VRE_RESP_OKAY))
        else $error("raw status read mismatch");

    a_raw_negated: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL6]
        (forced == `VRE_RESET_WORD) && (u_gate.req_sync == `VRE_RESET_WORD) |-> (raw_status == `VRE_RESET_WORD))
        else $error("raw status set with no source");

    a_enable_gate: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL8]
        ##1 (ENABLED_REQ == ($past(raw_status) & $past(enable))))
        else $error("enabled vector not gated by enable");

    a_enable_read: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL9]
        s_read_at(`VRE_ADDR_ENABLE_SET) |=> (S_AXI_RDATA == $past(enable)))
        else $error("enable read mismatch");

    a_enable_set: assert property (@(posedge MCLK) disable iff (!RESETN)  // [RL10]
        s_exec_at(`VRE_ADDR_ENABLE_SET) |=> (enable == ($past(enable) | $past(wr_ones))))
        else $error("enable set wrong");

    a_enable_reset: assert property (@(posedge MCLK)  // [RL11]
        $past(!RESETN) |-> (enable == `VRE_RESET_WORD) && (forced == `VRE_RESET_WORD))
        else $error("enable or forced not zero after reset");

    a_write_answer: assert property (@(posedge MCLK) disable iff (!RESETN)
        wr_exec |=> S_AXI_BVALID)
        else $error("write response missing");

endmodule : vre_controller

// ==== tb/vre_req_source.sv ====
/*
 * Model of the peripheral request sources that feed the raw request stage.
 * Assumes the bench sets the wanted line pattern and a lag of 0 to 15 cycles.
 */
`timescale 1ns/1ps

module vre_req_source (
    input wire logic clk,
    input wire vre_pkg::vre_req_vec_type want,
    input wire logic [3:0] lag,
    output vre_pkg::vre_req_vec_type lines
);
    vre_pkg::vre_req_vec_type held = '0;
    logic [3:0] wait_count = 4'h0;

    assign lines = held;

    // A slow source takes lag plus one cycles to show a new pattern
    always @(posedge clk) begin
        if (held == want) begin
            wait_count <= 4'h0;
        end else if (wait_count >= lag) begin
            held <= want;
        end else begin
            wait_count <= wait_count + 4'h1;
        end
    end
endmodule : vre_req_source

// ==== tb/vre_controller_tb_top.sv ====
/*
 * Self-checking bench of the raw request and enable stage, AXI4-Lite master tasks.
 * Assumes the map header, the package and the request source model are compiled first.
 */
`timescale 1ns/1ps
`include "vre_map.svh"

module vre_controller_tb_top;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq_out;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, enabled_req, hw, f, c, e1, e2;
    vre_pkg::vre_req_vec_type want = '0, lines, v;
    logic [3:0] lag = 4'h0;
    int num_errors = 0, comparisons = 0;

    always #2 mclk = ~mclk;

    vre_req_source src (.clk(mclk), .want(want), .lag(lag), .lines(lines));

    vre_controller uut (
        .MCLK(mclk), .RESETN(resetn),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .IRQ_REQ_IN(lines), .ENABLED_REQ(enabled_req), .IRQ_OUT(irq_out)
    );

    // ********************
    // Compare and report
    // ********************
    task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_word

    task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_resp

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // ********************
    // Bus master
    // ********************
    task automatic axi_write(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp);
        bit aw_on, w_on, done;
        @(posedge mclk);
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_on = 1;
        w_on = 1;
        done = 0;
        // Only the watchdog ends a wait for the answer
        while (!done) begin
            @(posedge mclk);
            if (!aw_on && !w_on && bvalid === 1'b1) begin
                bready <= 1'b0;
                cmp_resp("bresp", exp, bresp);
                done = 1;
            end
            if (aw_on && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_on = 0;
            end
            if (w_on && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_on = 0;
            end
        end
    endtask : axi_write

    task automatic chk_read(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
        bit ar_on, done;
        @(posedge mclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar_on = 1;
        done = 0;
        while (!done) begin
            @(posedge mclk);
            if (!ar_on && rvalid === 1'b1) begin
                rready <= 1'b0;
                cmp_word("rdata", exp, rdata);
                cmp_resp("rresp", exp_resp, rresp);
                done = 1;
            end
            if (ar_on && arready === 1'b1) begin
                arvalid <= 1'b0;
                ar_on = 0;
            end
        end
    endtask : chk_read

    task automatic chk_pos(input vre_pkg::vre_req_vec_type p, input logic [31:0] exp);
        want <= p;
        repeat (8) @(posedge mclk);
        chk_read(`VRE_ADDR_RAW_STATUS, exp, `VRE_RESP_OKAY);
    endtask : chk_pos

    // ********************
    // Scenarios
    // ********************
    initial begin
        void'($urandom(32'h1ba2_fd28));
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        cmp_word("enabled_req", 32'h0000_0000, enabled_req);
        chk_read(`VRE_ADDR_RAW_STATUS, 32'h0000_0000, `VRE_RESP_OKAY);
        chk_read(`VRE_ADDR_ENABLE_SET, 32'h0000_0000, `VRE_RESP_OKAY);
        chk_read(`VRE_ADDR_FORCED_CLEAR, 32'h0000_0000, `VRE_RESP_OKAY);
        for (int i = 0; i < 12; i++) begin
            hw = $urandom;
            lag <= 4'($urandom_range(0, 3));
            want <= hw;
            repeat (10) @(posedge mclk);
            chk_read(`VRE_ADDR_RAW_STATUS, hw, `VRE_RESP_OKAY);
        end
        lag <= 4'h0;
        v = '0;
        v.watchdog_request = 1'b1;
        chk_pos(v, 32'h0000_0001);
        v = '0;
        v.async_serial_b_request = 1'b1;
        chk_pos(v, 32'h0000_0080);
        v = '0;
        v.two_wire_a_request = 1'b1;
        chk_pos(v, 32'h0000_0200);
        v = '0;
        v.counter_block_d_request = 1'b1;
        chk_pos(v, 32'h0800_0000);
        hw = $urandom;
        f = $urandom;
        c = $urandom;
        want <= hw;
        axi_write(`VRE_ADDR_FORCED, f, `VRE_RESP_OKAY);
        repeat (8) @(posedge mclk);
        chk_read(`VRE_ADDR_RAW_STATUS, hw | f, `VRE_RESP_OKAY);
        want <= '0;
        axi_write(`VRE_ADDR_FORCED_CLEAR, c, `VRE_RESP_OKAY);
        repeat (8) @(posedge mclk);
        chk_read(`VRE_ADDR_RAW_STATUS, f & ~c, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_FORCED_CLEAR, 32'h0000_0000, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_RAW_STATUS, 32'hFFFF_FFFF, `VRE_RESP_SLVERR);
        chk_read(`VRE_ADDR_RAW_STATUS, f & ~c, `VRE_RESP_OKAY);
        chk_read(32'hFFFF_F0F0, 32'h0000_0000, `VRE_RESP_SLVERR);
        axi_write(`VRE_ADDR_FORCED_CLEAR, 32'hFFFF_FFFF, `VRE_RESP_OKAY);
        // Only the strobed lane may take the ones
        wstrb <= 4'h2;
        axi_write(`VRE_ADDR_FORCED, 32'hFFFF_FFFF, `VRE_RESP_OKAY);
        wstrb <= 4'hF;
        chk_read(`VRE_ADDR_FORCED, 32'h0000_FF00, `VRE_RESP_OKAY);
        chk_read(`VRE_ADDR_RAW_STATUS, 32'h0000_FF00, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_FORCED_CLEAR, 32'hFFFF_FFFF, `VRE_RESP_OKAY);
        e1 = $urandom;
        e2 = $urandom;
        axi_write(`VRE_ADDR_ENABLE_SET, e1, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_ENABLE_SET, e2, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_ENABLE_SET, 32'h0000_0000, `VRE_RESP_OKAY);
        chk_read(`VRE_ADDR_ENABLE_SET, e1 | e2, `VRE_RESP_OKAY);
        hw = $urandom;
        want <= hw;
        repeat (8) @(posedge mclk);
        cmp_word("enabled_req", hw & (e1 | e2), enabled_req);
        want <= '0;
        // Event status keeps what was seen above, so mask first
        axi_write(`VRE_ADDR_EVENT_MASK, 32'h0000_0000, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_ENABLE_SET, 32'h0000_0010, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_FORCED, 32'h0000_0010, `VRE_RESP_OKAY);
        repeat (8) @(posedge mclk);
        cmp_word("irq_out", 32'h0000_0000, {31'h0, irq_out});
        axi_write(`VRE_ADDR_EVENT_MASK, 32'h0000_0010, `VRE_RESP_OKAY);
        repeat (4) @(posedge mclk);
        cmp_word("irq_out", 32'h0000_0001, {31'h0, irq_out});
        chk_read(`VRE_ADDR_EVENT_MASK, 32'h0000_0010, `VRE_RESP_OKAY);
        axi_write(`VRE_ADDR_FORCED_CLEAR, 32'h0000_0010, `VRE_RESP_OKAY);
        repeat (6) @(posedge mclk);
        axi_write(`VRE_ADDR_EVENT_STATUS, 32'hFFFF_FFFF, `VRE_RESP_OKAY);
        repeat (4) @(posedge mclk);
        cmp_word("irq_out", 32'h0000_0000, {31'h0, irq_out});
        chk_read(`VRE_ADDR_EVENT_STATUS, 32'h0000_0000, `VRE_RESP_OKAY);
        // Second reset with enable bits set must bring them back to zero
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        chk_read(`VRE_ADDR_ENABLE_SET, 32'h0000_0000, `VRE_RESP_OKAY);
        chk_read(`VRE_ADDR_RAW_STATUS, 32'h0000_0000, `VRE_RESP_OKAY);
        print_verdict;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        print_verdict;
    end
endmodule : vre_controller_tb_top
